// File: ifd_pkg.sv
// package: constants, field layout and types for the instruction decoder
package ifd_pkg;
  localparam logic [7:0]  OPC_IDLE      = 8'h00; // idle_slot_op
  localparam logic [7:0]  OPC_FAR_JUMP  = 8'h02;
  localparam logic [7:0]  OPC_FAR_CALL  = 8'h04;
  localparam logic [7:0]  OPC_FAR_MOVE  = 8'h08;
  localparam logic [3:0]  CJMP_UNCOND   = 4'hf;  // jump_op
  localparam logic [7:0]  OPC_INT_RET   = 8'h91; // interrupt_return_op
  localparam logic [3:0]  ACC_REG       = 4'h0;  // file_op_accumulator
  localparam logic [9:0]  LIT_BYTE_MAX  = 10'h0ff;
  localparam logic [12:0] FILE_ADDR_MAX = 13'h1fff;
  localparam int          F_OPC  = 16;
  localparam int          F_DST  = 12;
  localparam int          F_BASE = 8;
  localparam int          F_SRC  = 4;
  localparam int          F_SMOD = 2;
  localparam int          F_DMOD = 0;
  localparam int          F_LIT  = 4;
  localparam int          F_LITD = 8;
  localparam int          F_TOF  = 15;
  localparam int          F_FAR2 = 7;
  localparam logic [1:0]  CYC_ONE   = 2'h1;
  localparam logic [1:0]  CYC_TWO   = 2'h2;
  localparam logic [1:0]  CYC_THREE = 2'h3;
  typedef enum logic [3:0] {
    CLS_IDLE, CLS_W3, CLS_LIT, CLS_CJMP, CLS_JUMP, CLS_FILE, CLS_BITL,
    CLS_BITI, CLS_SKIP, CLS_TABLE, CLS_RET, CLS_DMOV, CLS_FAR
  } ifd_cls_t;
  typedef enum logic [1:0] {WID_WORD = 2'h0, WID_BYTE = 2'h1, WID_DWORD = 2'h2} ifd_wid_t;
  typedef struct packed {
    ifd_cls_t    cls;
    ifd_wid_t    width;
    logic [3:0]  base;
    logic [3:0]  src;
    logic [3:0]  dst;
    logic [1:0]  src_mode;
    logic [1:0]  dst_mode;
    logic [12:0] file_addr;
    logic        to_file;
    logic [3:0]  bit_sel;
    logic        bit_indirect;
    logic [9:0]  lit10;
    logic [15:0] soff;
    logic [22:0] prog_addr;
  } ifd_dec_t;
  typedef struct packed {
    logic c;
    logic digit_carry_flag;
    logic n;
    logic arith_wrap_flag;
    logic z;
  } ifd_flags_t;
endpackage

// File: ifd_decoder.sv
// module: instruction word decoder with cycle timing and status flags
module ifd_decoder (
  input  wire logic               sys_clk,      // instruction-cycle clock
  input  wire logic               rst,          // async reset, high
  input  wire logic               clk_en,       // freezes all state when low
  input  wire logic               instr_valid,  // fetched word present
  input  wire logic [23:0]        instr_word,   // fetched program word
  output logic                    fetch_ready,  // decoder can take a word (low while stalled)
  input  wire logic               cond_true,    // test result for jump or skip
  input  wire logic               flag_we,      // datapath flag update
  input  wire logic               sticky_z,     // zero flag may only clear
  input  wire ifd_pkg::ifd_flags_t flag_in,     // flags from datapath
  output logic                    exec_valid,   // decoded instruction pulse
  output ifd_pkg::ifd_dec_t       dec,          // decoded fields
  output logic                    idle_slot,    // idle cycle pulse
  output logic                    instr_done,   // instruction finished pulse
  output logic [1:0]              instr_cycles, // cycles of last instruction
  output ifd_pkg::ifd_flags_t     flags,        // status flags
  output logic                    lit_range_err,// byte literal above 255
  output logic                    word2_err,    // bad second word
  output logic                    addr_lsb_err  // odd program address
);
  typedef enum logic [2:0] {
    ST_ISSUE = 3'h0, ST_WORD2 = 3'h1, ST_STALL = 3'h3,
    ST_SKIP = 3'h2, ST_SKIP2 = 3'h6
  } ifd_state_t;

  // ************************************
  // decode functions
  // ************************************
  function automatic logic is_far(input logic [7:0] o);
    return (o == ifd_pkg::OPC_FAR_JUMP) || (o == ifd_pkg::OPC_FAR_CALL)
        || (o == ifd_pkg::OPC_FAR_MOVE);
  endfunction

  function automatic ifd_pkg::ifd_cls_t cls_of(input logic [7:0] o);
    case (o[7:4])
      4'h0: cls_of = (o == ifd_pkg::OPC_IDLE) ? ifd_pkg::CLS_IDLE
                   : is_far(o) ? ifd_pkg::CLS_FAR : ifd_pkg::CLS_JUMP;
      4'h2: cls_of = ifd_pkg::CLS_LIT;
      4'h3: cls_of = (o[3:0] == ifd_pkg::CJMP_UNCOND) ? ifd_pkg::CLS_JUMP
                   : ifd_pkg::CLS_CJMP;
      4'h4: cls_of = ifd_pkg::CLS_FILE;
      4'h5: cls_of = ifd_pkg::CLS_BITL;
      4'h6: cls_of = ifd_pkg::CLS_BITI;
      4'h7: cls_of = ifd_pkg::CLS_SKIP;
      4'h8: cls_of = ifd_pkg::CLS_TABLE;
      4'h9: cls_of = ifd_pkg::CLS_RET;
      4'ha: cls_of = ifd_pkg::CLS_DMOV;
      default: cls_of = ifd_pkg::CLS_W3;
    endcase
  endfunction

  function automatic ifd_pkg::ifd_wid_t wid_of(input logic [1:0] s);
    case (s)
      2'h1: wid_of = ifd_pkg::WID_BYTE;
      2'h2: wid_of = ifd_pkg::WID_DWORD;
      default: wid_of = ifd_pkg::WID_WORD;
    endcase
  endfunction

  function automatic ifd_pkg::ifd_dec_t decode(input logic [23:0] w);
    ifd_pkg::ifd_dec_t d;
    logic [7:0] o;
    o = w[ifd_pkg::F_OPC +: 8];
    d = '0;
    d.cls = cls_of(o);
    d.width = wid_of(o[1:0]);
    d.dst = w[ifd_pkg::F_DST +: 4];
    d.base = w[ifd_pkg::F_BASE +: 4];
    d.src = w[ifd_pkg::F_SRC +: 4];
    d.src_mode = w[ifd_pkg::F_SMOD +: 2];
    d.dst_mode = w[ifd_pkg::F_DMOD +: 2];
    case (d.cls)
      ifd_pkg::CLS_FILE:
      begin
        d.file_addr = w[12:0];
        d.to_file = w[ifd_pkg::F_TOF];
        if (!d.to_file)
          d.dst = ifd_pkg::ACC_REG;
      end
      ifd_pkg::CLS_BITL:
      begin
        d.bit_sel = w[ifd_pkg::F_DST +: 4];
        d.src = w[3:0];
      end
      ifd_pkg::CLS_BITI:
      begin
        d.bit_indirect = 1'b1;
        d.src = w[3:0];
      end
      ifd_pkg::CLS_LIT:
      begin
        d.base = w[3:0];
        if (o[2])
        begin
          d.lit10 = {2'h0, w[ifd_pkg::F_LITD +: 8]};
          d.dst = w[ifd_pkg::F_SRC +: 4];
        end
        else
        begin
          d.lit10 = w[ifd_pkg::F_LIT +: 10];
          d.dst = w[3:0];
        end
      end
      ifd_pkg::CLS_CJMP, ifd_pkg::CLS_JUMP:
        d.soff = {{6{w[9]}}, w[9:0]};
      ifd_pkg::CLS_FAR, ifd_pkg::CLS_DMOV:
        d.prog_addr = {7'h00, w[15:0]};
      default: d.lit10 = '0;
    endcase
    return d;
  endfunction

  function automatic logic [1:0] extra_of(input ifd_pkg::ifd_cls_t c, input logic t);
    case (c)
      ifd_pkg::CLS_JUMP, ifd_pkg::CLS_TABLE, ifd_pkg::CLS_DMOV: extra_of = 2'h1;
      ifd_pkg::CLS_RET:  extra_of = 2'h2;
      ifd_pkg::CLS_CJMP: extra_of = t ? 2'h1 : 2'h0;
      default: extra_of = 2'h0;
    endcase
  endfunction

  // ************************************
  // sequencing
  // ************************************
  ifd_state_t        state_reg, state_next;
  logic [1:0]        stall_reg;
  logic [1:0]        cnt_reg;
  logic [15:0]       word1_reg;
  logic [7:0]        opc_in;
  logic              two_in, take, finish;
  ifd_pkg::ifd_cls_t cls_in;
  logic [1:0]        extra_in;

  assign opc_in = instr_word[ifd_pkg::F_OPC +: 8];
  assign cls_in = cls_of(opc_in);
  assign two_in = is_far(opc_in);
  assign extra_in = extra_of(cls_in, cond_true);
  assign fetch_ready = (state_reg != ST_STALL);
  assign take = clk_en && instr_valid && fetch_ready;
  assign finish = clk_en && (state_next == ST_ISSUE)
               && (take || state_reg == ST_STALL);

  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      ST_ISSUE:
        if (take)
        begin
          if (two_in)
            state_next = ST_WORD2;
          else if (cls_in == ifd_pkg::CLS_SKIP && cond_true)
            state_next = ST_SKIP;
          else if (extra_in != 2'h0)
            state_next = ST_STALL;
        end
      ST_WORD2:
        if (take)
          state_next = ST_ISSUE;
      ST_SKIP:
        if (take)
          state_next = two_in ? ST_SKIP2 : ST_ISSUE;
      ST_SKIP2:
        if (take)
          state_next = ST_ISSUE;
      ST_STALL:
        if (clk_en && stall_reg == 2'h1)
          state_next = ST_ISSUE;
      default: state_next = ST_ISSUE;
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst)
    if (rst)
      state_reg <= ST_ISSUE;
    else if (clk_en)
      state_reg <= state_next;

  always_ff @(posedge sys_clk or posedge rst)
    if (rst)
      stall_reg <= 2'h0;
    else if (take && state_reg == ST_ISSUE)
      stall_reg <= extra_in;
    else if (clk_en && state_reg == ST_STALL)
      stall_reg <= stall_reg - 2'h1;

  always_ff @(posedge sys_clk or posedge rst)
    if (rst)
      cnt_reg <= 2'h0;
    else if (take && state_reg == ST_ISSUE)
      cnt_reg <= ifd_pkg::CYC_ONE;
    else if (take || (clk_en && state_reg == ST_STALL))
      cnt_reg <= cnt_reg + 2'h1;

  always_ff @(posedge sys_clk or posedge rst)
    if (rst)
    begin
      instr_done <= 1'b0;
      instr_cycles <= 2'h0;
    end
    else if (clk_en)
    begin
      instr_done <= finish;
      if (finish)
        instr_cycles <= (state_reg == ST_ISSUE) ? ifd_pkg::CYC_ONE : cnt_reg + 2'h1;
    end

  // ************************************
  // decode output
  // ************************************
  always_ff @(posedge sys_clk or posedge rst)
    if (rst)
      word1_reg <= 16'h0000;
    else if (take && state_reg == ST_ISSUE)
      word1_reg <= instr_word[15:0];

  always_ff @(posedge sys_clk or posedge rst)
    if (rst)
    begin
      exec_valid <= 1'b0;
      dec <= '0;
    end
    else if (clk_en)
    begin
      exec_valid <= 1'b0;
      if (take && state_reg == ST_ISSUE)
      begin
        dec <= decode(instr_word);
        exec_valid <= !two_in;
      end
      else if (take && state_reg == ST_WORD2)
      begin
        exec_valid <= 1'b1;
        if (dec.cls == ifd_pkg::CLS_FAR)
          dec.prog_addr <= {instr_word[ifd_pkg::F_FAR2-1:0], word1_reg[15:1], 1'b0};
        else
          dec.dst <= instr_word[3:0];
      end
    end

  always_ff @(posedge sys_clk or posedge rst)
    if (rst)
      idle_slot <= 1'b0;
    else if (clk_en)
      idle_slot <= (take && (state_reg == ST_SKIP || state_reg == ST_SKIP2))
                || state_reg == ST_STALL;

  always_ff @(posedge sys_clk or posedge rst)
    if (rst)
    begin
      lit_range_err <= 1'b0;
      word2_err <= 1'b0;
      addr_lsb_err <= 1'b0;
    end
    else if (clk_en)
    begin
      lit_range_err <= take && state_reg == ST_ISSUE && cls_in == ifd_pkg::CLS_LIT
                    && !opc_in[2] && wid_of(opc_in[1:0]) == ifd_pkg::WID_BYTE
                    && instr_word[ifd_pkg::F_LIT +: 10] > ifd_pkg::LIT_BYTE_MAX;
      word2_err <= take && state_reg == ST_WORD2 && opc_in != ifd_pkg::OPC_IDLE;
      addr_lsb_err <= take && state_reg == ST_WORD2 && word1_reg[0]
                   && dec.cls == ifd_pkg::CLS_FAR;
    end

  // ************************************
  // status flags
  // ************************************
  always_ff @(posedge sys_clk or posedge rst)
    if (rst)
      flags <= '0;
    else if (clk_en && flag_we && exec_valid && dec.cls != ifd_pkg::CLS_IDLE)
    begin
      flags <= flag_in;
      flags.z <= sticky_z ? (flags.z && flag_in.z) : flag_in.z;
    end

  // ************************************
  // checks
  // ************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  two_word_cyc_a: assert property (take && state_reg == ST_WORD2 |=> instr_done && instr_cycles == 2'h2)
    else $error("two-word instruction not two cycles");
  skip_two_a: assert property (take && state_reg == ST_SKIP && !two_in |=> instr_cycles == 2'h2)
    else $error("skip over one word not two cycles");
  skip_three_a: assert property (take && state_reg == ST_SKIP2 |=> instr_done && instr_cycles == 2'h3)
    else $error("skip over two words not three cycles");
  plain_one_a: assert property (take && state_reg == ST_ISSUE && !two_in && extra_in == 2'h0
      && cls_in != ifd_pkg::CLS_SKIP |=> instr_done && instr_cycles == 2'h1)
    else $error("plain instruction not one cycle");
  taken_stall_a: assert property (take && state_reg == ST_ISSUE && cls_in == ifd_pkg::CLS_CJMP
      && cond_true |=> !fetch_ready)
    else $error("taken jump did not stall");
  return_three_a: assert property (instr_done && dec.cls == ifd_pkg::CLS_RET |-> instr_cycles == 2'h3)
    else $error("return not three cycles");
  lone_idle_a: assert property (take && state_reg == ST_ISSUE && opc_in == ifd_pkg::OPC_IDLE
      |=> exec_valid && dec.cls == ifd_pkg::CLS_IDLE)
    else $error("lone second word not idle");
  far_lsb_a: assert property (exec_valid && dec.cls == ifd_pkg::CLS_FAR |-> !dec.prog_addr[0])
    else $error("program address lsb set");
  lit_cap_a: assert property (take && state_reg == ST_ISSUE && opc_in == 8'h21
      && instr_word[13] |=> lit_range_err)
    else $error("byte literal range not flagged");
  word2_chk_a: assert property (take && state_reg == ST_WORD2 && opc_in != 8'h00 |=> word2_err)
    else $error("bad second word not flagged");
  sticky_z_a: assert property (clk_en && flag_we && exec_valid && sticky_z && !flags.z |=> !flags.z)
    else $error("sticky zero set");
  soff_sign_a: assert property (exec_valid && dec.cls == ifd_pkg::CLS_CJMP
      |-> dec.soff[15:9] == {7{dec.soff[9]}})
    else $error("signed literal not extended");

  far_c: cover property (take && state_reg == ST_WORD2);
  skip_c: cover property (take && state_reg == ST_SKIP2);
  ret_c: cover property (instr_done && instr_cycles == 2'h3);
endmodule

// File: ifd_fetch_model.sv
// test model of the fetch path and datapath test result feeding the decoder
module ifd_fetch_model (
  input  wire logic   sys_clk,     // instruction-cycle clock
  input  wire logic   rst,         // async reset, high
  input  wire logic   clk_en,      // decoder clock enable
  input  wire logic   fetch_ready, // decoder can take a word
  input  wire logic   slow,        // hold back the next word
  output logic        instr_valid, // word offered
  output logic [23:0] instr_word,  // offered word
  output logic        cond_true,   // test result offered with the word
  output logic        empty        // program used up
);
  logic [24:0] prog_q[$];
  logic        taken;

  task automatic put(input logic [24:0] entry);
    prog_q.push_back(entry);
  endtask

  // ****************
  // offer words in order, hold each until taken
  // ****************
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      instr_valid <= 1'b0;
      instr_word  <= 24'h0;
      cond_true   <= 1'b0;
      empty       <= 1'b0;
    end
    else
    begin
      taken = clk_en && instr_valid && fetch_ready;
      if (taken)
        void'(prog_q.pop_front());
      if (!instr_valid || taken)
      begin
        if (!slow && prog_q.size() != 0)
        begin
          instr_valid <= 1'b1;
          instr_word  <= prog_q[0][23:0];
          cond_true   <= prog_q[0][24];
        end
        else
        begin
          // released lines toggle so no stale word looks valid
          instr_valid <= 1'b0;
          instr_word  <= ~instr_word;
          cond_true   <= ~cond_true;
        end
      end
      empty <= (prog_q.size() == 0);
    end
  end
endmodule

// File: instruction_format_timing_bench.sv
// self-checking bench for the instruction decoder
module instruction_format_timing_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic                sys_clk, rst, clk_en, flag_we, sticky_z, slow, skip_open;
  logic                instr_valid, fetch_ready, cond_true, empty, exec_valid;
  logic                idle_slot, instr_done, lit_range_err, word2_err, addr_lsb_err;
  logic [23:0]         instr_word;
  logic [1:0]          instr_cycles;
  ifd_pkg::ifd_flags_t flag_in, flags, exp_fl;
  ifd_pkg::ifd_dec_t   dec;
  ifd_pkg::ifd_cls_t   cls_q[$];
  logic [32:0]         key_q[$];
  logic [1:0]          cyc_q[$];
  integer              seed = 32'ha7b2;
  int                  n_mismatch, samples_checked, n_lit, n_w2, n_odd, n_idle;
  int                  e_lit, e_w2, e_odd, e_idle;
  logic [7:0]          opc_tab [19] = '{8'h10, 8'h11, 8'h12, 8'h20, 8'h21, 8'h25, 8'h30,
    8'h3f, 8'h40, 8'h50, 8'h60, 8'h70, 8'h80, 8'h91, 8'ha0, 8'h00, 8'h02, 8'h04, 8'h08};
  logic [1:0]          cyc_tab [16] = '{2'h1, 2'h1, 2'h1, 2'h1, 2'h1, 2'h1, 2'h1, 2'h1,
    2'h2, 2'h3, 2'h2, 2'h1, 2'h1, 2'h1, 2'h1, 2'h1};

  ifd_decoder ifd_decoder_inst (.sys_clk(sys_clk), .rst(rst), .clk_en(clk_en),
    .instr_valid(instr_valid), .instr_word(instr_word), .fetch_ready(fetch_ready),
    .cond_true(cond_true), .flag_we(flag_we), .sticky_z(sticky_z), .flag_in(flag_in),
    .exec_valid(exec_valid), .dec(dec), .idle_slot(idle_slot), .instr_done(instr_done),
    .instr_cycles(instr_cycles), .flags(flags), .lit_range_err(lit_range_err),
    .word2_err(word2_err), .addr_lsb_err(addr_lsb_err));
  ifd_fetch_model ifd_fetch_model_inst (.sys_clk(sys_clk), .rst(rst), .clk_en(clk_en),
    .fetch_ready(fetch_ready), .slow(slow), .instr_valid(instr_valid),
    .instr_word(instr_word), .cond_true(cond_true), .empty(empty));

  // ****************
  // expectations
  // ****************
  function automatic ifd_pkg::ifd_cls_t cls_of(input logic [7:0] op);
    if (op == 8'h3f)
      return ifd_pkg::CLS_JUMP;
    if (op[7:4] == 4'h0 && op != 8'h00)
      return ifd_pkg::CLS_FAR;
    // opcode groups follow the class order, skipping the jump class
    return ifd_pkg::ifd_cls_t'(op[7:4] + 4'(op[7:4] > 4'h3));
  endfunction

  function automatic logic [32:0] exp_key(input logic [7:0] op, input logic [15:0] lo,
                                          input logic [23:0] w2);
    logic [1:0] wd;
    wd = (op[1:0] == 2'b01) ? 2'h1 : ((op[1:0] == 2'b10) ? 2'h2 : 2'h0);
    case (op[7:4])
      4'h1: return {15'h0, wd, lo};
      4'h2: return op[2] ? {17'h0, wd, lo[7:4], 2'h0, lo[15:8]} : {17'h0, wd, lo[3:0], lo[13:4]};
      4'h4: return {15'h0, ifd_pkg::ACC_REG, lo[15], lo[12:0]};
      4'h3: return {17'h0, 16'($signed(lo[9:0]))};
      4'h5: return {20'h0, 1'b0, lo[15:12], lo[11:8], lo[3:0]};
      4'h6: return {20'h0, 1'b1, 4'h0, lo[11:8], lo[3:0]};
      4'h0: return (op == 8'h00) ? 33'h0 : ((w2[23:16] != 8'h0) ? {1'b1, 32'h0}
             : {10'h0, w2[6:0], lo[15:1], 1'b0});
      default: return 33'h0;
    endcase
  endfunction

  function automatic logic [32:0] act_key(input ifd_pkg::ifd_dec_t d);
    case (d.cls)
      ifd_pkg::CLS_W3: return {15'h0, d.width, d.dst, d.base, d.src, d.src_mode, d.dst_mode};
      ifd_pkg::CLS_LIT: return {17'h0, d.width, d.dst, d.lit10};
      ifd_pkg::CLS_FILE: return {15'h0, d.to_file ? 4'h0 : d.dst, d.to_file, d.file_addr};
      ifd_pkg::CLS_FAR: return {10'h0, d.prog_addr};
      ifd_pkg::CLS_CJMP, ifd_pkg::CLS_JUMP: return {17'h0, d.soff};
      ifd_pkg::CLS_BITL, ifd_pkg::CLS_BITI: return {20'h0, d.bit_indirect, d.bit_sel, d.base, d.src};
      default: return 33'h0;
    endcase
  endfunction

  task automatic emit(input logic [7:0] op, input logic [15:0] lo, input logic [23:0] w2,
                      input logic c);
    logic       two;
    logic [1:0] cy;
    two = (op == 8'h02) || (op == 8'h04) || (op == 8'h08);
    ifd_fetch_model_inst.put({c, op, lo});
    if (two)
      ifd_fetch_model_inst.put({1'b0, w2});
    if (skip_open)
    begin
      cy = two ? 2'h3 : 2'h2;
      skip_open = 1'b0;
    end
    else
    begin
      cls_q.push_back(cls_of(op));
      key_q.push_back(exp_key(op, lo, w2));
      cy = (op[7:4] == 4'h3 && (c || op[3:0] == 4'hf)) ? 2'h2 : cyc_tab[op[7:4]];
      if (two)
        cy = 2'h2;
      skip_open = (op[7:4] == 4'h7) && c;
      e_lit += int'(op == 8'h21 && lo[13:4] > ifd_pkg::LIT_BYTE_MAX);
      e_odd += int'(two && lo[0]);
      e_w2 += int'(two && w2[23:16] != 8'h0);
    end
    if (!skip_open)
    begin
      cyc_q.push_back(cy);
      e_idle += int'(cy) - 1 - int'(two && cy == 2'h2);
    end
  endtask

  task automatic check(input string what, input logic [32:0] exp, input logic [32:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      n_mismatch++;
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // ****************
  // clock, random drive, monitor
  // ****************
  initial
  begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk)
  begin
    clk_en   <= ($random(seed) & 7) != 0;
    slow     <= ($random(seed) & 3) == 0;
    flag_we  <= 1'($random(seed));
    sticky_z <= 1'($random(seed));
    flag_in  <= 5'($random(seed));
  end

  always @(posedge sys_clk)
  begin
    if (!rst)
    begin
      check("flags", 33'(exp_fl), 33'(flags));
      if (clk_en)
      begin
        if (flag_we && exec_valid && dec.cls != ifd_pkg::CLS_IDLE)
          exp_fl = {flag_in[4:1], sticky_z ? (exp_fl.z & flag_in.z) : flag_in.z};
        if (exec_valid && cls_q.size() == 0)
          check("extra instruction", 33'h0, 33'h1);
        else if (exec_valid)
        begin
          check("class", 33'(cls_q.pop_front()), 33'(dec.cls));
          if (!key_q[0][32])
            check("fields", key_q[0], act_key(dec));
          void'(key_q.pop_front());
        end
        if (instr_done && cyc_q.size() == 0)
          check("extra completion", 33'h0, 33'h1);
        else if (instr_done)
          check("cycles", 33'(cyc_q.pop_front()), 33'(instr_cycles));
        n_lit += int'(lit_range_err);
        n_w2 += int'(word2_err);
        n_odd += int'(addr_lsb_err);
        n_idle += int'(idle_slot);
      end
    end
  end

  initial
  begin
    repeat (20000) @(posedge sys_clk);
    n_mismatch++;
    end_sim();
  end

  // ****************
  // main sequence
  // ****************
  initial
  begin
    rst = 1'b1;
    clk_en = 1'b0;
    slow = 1'b0;
    flag_we = 1'b0;
    sticky_z = 1'b0;
    flag_in = '0;
    exp_fl = '0;
    skip_open = 1'b0;
    emit(8'h21, 16'h1000, 24'h0, 1'b0);
    emit(8'h20, 16'h3ff5, 24'h0, 1'b0);
    emit(8'h25, 16'hab3c, 24'h0, 1'b0);
    emit(8'h02, 16'h1235, 24'h00007f, 1'b0);
    emit(8'h08, 16'h2000, 24'h010005, 1'b0);
    emit(8'h70, 16'h0, 24'h0, 1'b1);
    emit(8'h04, 16'h4444, 24'h000011, 1'b0);
    emit(8'h70, 16'h0, 24'h0, 1'b1);
    emit(8'h12, 16'h5a5a, 24'h0, 1'b0);
    emit(8'h30, 16'h0, 24'h0, 1'b1);
    emit(8'h30, 16'h0, 24'h0, 1'b0);
    emit(8'h00, 16'hbeef, 24'h0, 1'b1);
    emit(8'h40, 16'h9fff, 24'h0, 1'b0);
    for (int i = 0; i < 250; i++)
      emit(opc_tab[$unsigned($random(seed)) % 19], 16'($random(seed)),
           {8'h0, 16'($random(seed))}, 1'($random(seed)));
    repeat (3) emit(8'h10, 16'($random(seed)), 24'h0, 1'b0);
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    for (int i = 0; i < 8000 && !(empty && cyc_q.size() == 0); i++)
      @(posedge sys_clk);
    repeat (4) @(posedge sys_clk);
    check("pending instructions", 33'h0, 33'(cyc_q.size() + cls_q.size()));
    check("range errors", 33'(e_lit), 33'(n_lit));
    check("second word errors", 33'(e_w2), 33'(n_w2));
    check("odd address errors", 33'(e_odd), 33'(n_odd));
    check("idle slots", 33'(e_idle), 33'(n_idle));
    end_sim();
  end
endmodule
